/* File: src/cpu_subset_pkg.sv */
// Shared constants and types for the instruction subset executor
package cpu_subset_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int JUMP_W = 11;
  localparam int DEST_BIT = 7;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  localparam int OPC6_HI = 13;
  localparam int OPC6_LO = 8;
  localparam int OPC3_LO = 11;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [13:0] OPC_CLEAR_ACC = 14'h0103;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_ONE = 13'h0001;
  localparam logic [6:0] FADDR_RESET = 7'h00;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_CLEAR_ACC,
    OP_DEC_SKIP,
    OP_INC_SKIP,
    OP_INC,
    OP_OR_LIT,
    OP_JUMP
  } op_e;

  typedef enum logic {
    ST_EXEC,
    ST_FLUSH
  } state_e;
endpackage

/* File: src/instr_decode.sv */
// Instruction word decoder for the executed subset
`timescale 1ns/1ps
`default_nettype none
module instr_decode
  import cpu_subset_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr_i,
  output op_e op_o,
  output logic dest_file_o,
  output logic [FADDR_W-1:0] faddr_o,
  output logic [DATA_W-1:0] literal_o,
  output logic [JUMP_W-1:0] jump_k_o
);
  always_comb begin
    dest_file_o = instr_i[DEST_BIT];
    faddr_o = instr_i[FADDR_W-1:0];
    literal_o = instr_i[DATA_W-1:0];
    jump_k_o = instr_i[JUMP_W-1:0];
    if (instr_i == OPC_CLEAR_ACC) begin
      op_o = OP_CLEAR_ACC;
    end else if (instr_i[INSTR_W-1:OPC3_LO] == OPC_JUMP) begin
      op_o = OP_JUMP;
    end else begin
      case (instr_i[OPC6_HI:OPC6_LO])
        OPC_DEC_SKIP: op_o = OP_DEC_SKIP;
        OPC_INC_SKIP: op_o = OP_INC_SKIP;
        OPC_INC: op_o = OP_INC;
        OPC_OR_LIT: op_o = OP_OR_LIT;
        default: op_o = OP_NOP;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: src/subset_alu.sv */
// Result, destination and flag logic for the executed subset
`timescale 1ns/1ps
`default_nettype none
module subset_alu
  import cpu_subset_pkg::*;
(
  input wire op_e op_i,
  input wire logic dest_file_i,
  input wire logic [DATA_W-1:0] acc_i,
  input wire logic [DATA_W-1:0] fdata_i,
  input wire logic [DATA_W-1:0] literal_i,
  output logic [DATA_W-1:0] result_o,
  output logic result_zero_o,
  output logic write_acc_o,
  output logic write_file_o,
  output logic write_zero_o,
  output logic skip_o
);
  always_comb begin
    result_o = DATA_ZERO;
    write_acc_o = 1'b0;
    write_file_o = 1'b0;
    write_zero_o = 1'b0;
    case (op_i)
      OP_CLEAR_ACC: begin
        write_acc_o = 1'b1;
        write_zero_o = 1'b1;
      end
      OP_DEC_SKIP: begin
        result_o = fdata_i - DATA_ONE;
        write_acc_o = !dest_file_i;
        write_file_o = dest_file_i;
      end
      OP_INC_SKIP, OP_INC: begin
        result_o = fdata_i + DATA_ONE;
        write_acc_o = !dest_file_i;
        write_file_o = dest_file_i;
        write_zero_o = (op_i == OP_INC);
      end
      OP_OR_LIT: begin
        result_o = acc_i | literal_i;
        write_acc_o = 1'b1;
        write_zero_o = 1'b1;
      end
      default: begin
        result_o = DATA_ZERO;
      end
    endcase
    result_zero_o = (result_o == DATA_ZERO);
    skip_o = ((op_i == OP_DEC_SKIP) || (op_i == OP_INC_SKIP))
      && result_zero_o;
  end
endmodule
`default_nettype wire

/* File: src/cpu_instruction_subset_exec.sv */
// Execution core for clear, increment, decrement, OR-literal and jump
// Contract
// - Clear accumulator writes zero, sets zero flag
// - Decrement-skip subtracts one, routes by dest bit
// - Decrement-skip zero result replaces next with no-op
// - Nonzero skip result continues without skip cycle
// - Increment-skip adds one, routes, flags untouched
// - Increment-skip zero result replaces next with no-op
// - Jump loads 11-bit operand into counter low
// - Jump copies latch bits 4:3 to 12:11
// - Jump takes two cycles, flags untouched
// - OR-literal ORs accumulator, updates zero flag
// - Increment adds one, routes, updates zero flag
//
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_subset_exec
  import cpu_subset_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic [DATA_W-1:0] upper_jump_latch_i,
  output logic [PC_W-1:0] program_counter_o,
  output logic [FADDR_W-1:0] file_raddr_o,
  output logic file_we_o,
  output logic [FADDR_W-1:0] file_waddr_o,
  output logic [DATA_W-1:0] file_wdata_o,
  output logic [DATA_W-1:0] accumulator_o,
  output logic zero_flag_o,
  output logic flush_o
);
  op_e dec_op;
  op_e op_w;
  state_e state_q;
  state_e state_d;
  logic dest_file_w;
  logic [FADDR_W-1:0] faddr_w;
  logic [DATA_W-1:0] literal_w;
  logic [JUMP_W-1:0] jump_k_w;
  logic [DATA_W-1:0] operand_w;
  logic [DATA_W-1:0] result_w;
  logic result_zero_w;
  logic write_acc_w;
  logic write_file_w;
  logic write_zero_w;
  logic skip_w;
  logic exec_w;
  logic [PC_W-1:0] jump_target_w;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic jump_wait_q;
  logic jump_wait_d;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  logic zero_q;
  logic zero_d;
  logic we_q;
  logic we_d;
  logic [FADDR_W-1:0] waddr_q;
  logic [FADDR_W-1:0] waddr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;

  instr_decode u_decode (
    .instr_i(instr_i),
    .op_o(dec_op),
    .dest_file_o(dest_file_w),
    .faddr_o(faddr_w),
    .literal_o(literal_w),
    .jump_k_o(jump_k_w)
  );

  // Fetched word in a flush cycle is discarded and runs as a no-op
  assign exec_w = (state_q == ST_EXEC);
  assign op_w = exec_w ? dec_op : OP_NOP;

  // Forward the pending write so back-to-back file updates see fresh data
  assign operand_w = (we_q && (waddr_q == faddr_w)) ? wdata_q
    : file_rdata_i;

  subset_alu u_alu (
    .op_i(op_w),
    .dest_file_i(dest_file_w),
    .acc_i(acc_q),
    .fdata_i(operand_w),
    .literal_i(literal_w),
    .result_o(result_w),
    .result_zero_o(result_zero_w),
    .write_acc_o(write_acc_w),
    .write_file_o(write_file_w),
    .write_zero_o(write_zero_w),
    .skip_o(skip_w)
  );

  assign jump_target_w = {upper_jump_latch_i[LATCH_HI:LATCH_LO],
    jump_k_w};

  always_comb begin
    state_d = ST_EXEC;
    jump_wait_d = 1'b0;
    pc_d = pc_q + PC_ONE;
    if (!exec_w) begin
      state_d = ST_EXEC;
      // Target word is refetched after the dead cycle, so the count holds
      pc_d = jump_wait_q ? pc_q : pc_q + PC_ONE;
    end else if (op_w == OP_JUMP) begin
      // Target was loaded; its fetch waits out the dead cycle
      state_d = ST_FLUSH;
      jump_wait_d = 1'b1;
      pc_d = jump_target_w;
    end else if (skip_w) begin
      state_d = ST_FLUSH;
    end
  end

  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    we_d = write_file_w;
    waddr_d = faddr_w;
    wdata_d = result_w;
    if (write_acc_w) begin
      acc_d = result_w;
    end
    // Skip ops and jump leave write_zero low, so flags hold
    if (write_zero_w) begin
      zero_d = result_zero_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= ST_EXEC;
      jump_wait_q <= 1'b0;
      pc_q <= PC_RESET;
      acc_q <= ACC_RESET;
      zero_q <= 1'b0;
      we_q <= 1'b0;
      waddr_q <= FADDR_RESET;
      wdata_q <= DATA_ZERO;
    end else begin
      state_q <= state_d;
      jump_wait_q <= jump_wait_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      zero_q <= zero_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  assign program_counter_o = pc_q;
  assign file_raddr_o = faddr_w;
  assign file_we_o = we_q;
  assign file_waddr_o = waddr_q;
  assign file_wdata_o = wdata_q;
  assign accumulator_o = acc_q;
  assign zero_flag_o = zero_q;
  assign flush_o = !exec_w;

  property p_clear_acc;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_CLEAR_ACC) |=> (accumulator_o == DATA_ZERO)
      && zero_flag_o && (state_q == ST_EXEC);
  endproperty
  a_clear_acc: assert property (p_clear_acc)
    else $error("clear did not zero accumulator and set zero flag");

  property p_dec_to_acc;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_DEC_SKIP) && !dest_file_w |=>
      (accumulator_o == $past(operand_w) - DATA_ONE) && !file_we_o;
  endproperty
  a_dec_to_acc: assert property (p_dec_to_acc)
    else $error("decrement result not routed to accumulator");

  property p_skip_flags;
    @(posedge clk_i) disable iff (!reset_n_i)
    ((op_w == OP_DEC_SKIP) || (op_w == OP_INC_SKIP)
      || (op_w == OP_JUMP)) |=> $stable(zero_flag_o);
  endproperty
  a_skip_flags: assert property (p_skip_flags)
    else $error("skip or jump changed the zero flag");

  property p_dec_skip_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_DEC_SKIP) && (operand_w == DATA_ONE) |=>
      flush_o ##1 !flush_o && (program_counter_o == $past(pc_q, 2)
      + PC_ONE + PC_ONE);
  endproperty
  a_dec_skip_zero: assert property (p_dec_skip_zero)
    else $error("decrement to zero did not skip one word");

  property p_no_skip;
    @(posedge clk_i) disable iff (!reset_n_i)
    ((op_w == OP_DEC_SKIP) || (op_w == OP_INC_SKIP)) && !result_zero_w
      |=> !flush_o && (program_counter_o == $past(pc_q) + PC_ONE);
  endproperty
  a_no_skip: assert property (p_no_skip)
    else $error("nonzero skip result inserted a skip cycle");

  property p_inc_skip_file;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_INC_SKIP) && dest_file_w |=> file_we_o
      && (file_wdata_o == $past(operand_w) + DATA_ONE)
      && $stable(accumulator_o);
  endproperty
  a_inc_skip_file: assert property (p_inc_skip_file)
    else $error("increment-skip result not written to file");

  property p_flush_idle;
    @(posedge clk_i) disable iff (!reset_n_i)
    flush_o |=> $stable(accumulator_o) && $stable(zero_flag_o)
      && !file_we_o;
  endproperty
  a_flush_idle: assert property (p_flush_idle)
    else $error("discarded instruction had an effect");

  property p_jump_target;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_JUMP) |=> (program_counter_o == $past(jump_target_w))
      && flush_o ##1 (program_counter_o == $past(jump_target_w, 2));
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("jump target or two-cycle timing wrong");

  property p_or_lit;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_OR_LIT) |=>
      (accumulator_o == ($past(acc_q) | $past(literal_w)))
      && (zero_flag_o == (accumulator_o == DATA_ZERO));
  endproperty
  a_or_lit: assert property (p_or_lit)
    else $error("OR-literal result or zero flag wrong");

  property p_inc_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_INC) |=>
      (zero_flag_o == ($past(operand_w) + DATA_ONE == DATA_ZERO));
  endproperty
  a_inc_zero: assert property (p_inc_zero)
    else $error("increment did not update zero flag");

  property p_single_cycle;
    @(posedge clk_i) disable iff (!reset_n_i)
    !flush_o && (op_w != OP_JUMP) && !skip_w |=> !flush_o
      && (program_counter_o == $past(pc_q) + PC_ONE);
  endproperty
  a_single_cycle: assert property (p_single_cycle)
    else $error("plain instruction took more than one cycle");

  property p_dec_to_file;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_DEC_SKIP) && dest_file_w |=> file_we_o
      && (file_wdata_o == $past(operand_w) - DATA_ONE)
      && (file_waddr_o == $past(faddr_w)) && $stable(accumulator_o);
  endproperty
  a_dec_to_file: assert property (p_dec_to_file)
    else $error("decrement result not routed to file register");

  property p_inc_skip_acc;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_INC_SKIP) && !dest_file_w |=>
      (accumulator_o == $past(operand_w) + DATA_ONE) && !file_we_o;
  endproperty
  a_inc_skip_acc: assert property (p_inc_skip_acc)
    else $error("increment-skip result not routed to accumulator");

  property p_inc_skip_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_INC_SKIP) && (operand_w + DATA_ONE == DATA_ZERO) |=>
      flush_o ##1 !flush_o && (program_counter_o == $past(pc_q, 2)
      + PC_ONE + PC_ONE);
  endproperty
  a_inc_skip_zero: assert property (p_inc_skip_zero)
    else $error("increment to zero did not skip one word");

  property p_inc_to_file;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_INC) && dest_file_w |=> file_we_o
      && (file_wdata_o == $past(operand_w) + DATA_ONE)
      && $stable(accumulator_o);
  endproperty
  a_inc_to_file: assert property (p_inc_to_file)
    else $error("increment result not written to file");

  property p_inc_to_acc;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_INC) && !dest_file_w |=>
      (accumulator_o == $past(operand_w) + DATA_ONE) && !file_we_o;
  endproperty
  a_inc_to_acc: assert property (p_inc_to_acc)
    else $error("increment result not routed to accumulator");

  property p_jump_no_effect;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_JUMP) |=> $stable(accumulator_o) && !file_we_o;
  endproperty
  a_jump_no_effect: assert property (p_jump_no_effect)
    else $error("jump touched accumulator or file");

  property p_nop_idle;
    @(posedge clk_i) disable iff (!reset_n_i)
    (op_w == OP_NOP) |=> $stable(accumulator_o) && $stable(zero_flag_o)
      && !file_we_o;
  endproperty
  a_nop_idle: assert property (p_nop_idle)
    else $error("no-op changed accumulator, flag or file");
endmodule
`default_nettype wire

/* File: tb/cpu_instruction_subset_exec_tb.sv */
// Self-checking bench for the instruction subset executor
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_subset_exec_tb;
  import cpu_subset_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic [DATA_W-1:0] upper_jump_latch_i = '0;
  wire logic [DATA_W-1:0] file_rdata_i;
  logic [PC_W-1:0] program_counter_o;
  logic [FADDR_W-1:0] file_raddr_o;
  logic file_we_o;
  logic [FADDR_W-1:0] file_waddr_o;
  logic [DATA_W-1:0] file_wdata_o;
  logic [DATA_W-1:0] accumulator_o;
  logic zero_flag_o;
  logic flush_o;
  logic [7:0] fmem [128];
  logic [7:0] em [128];
  logic [12:0] m_pc;
  logic [7:0] m_acc, m_wd;
  logic [6:0] m_wa;
  logic m_z, m_we, m_fl, m_jp;
  int miscompares = 0;
  int samples_checked = 0;

  cpu_instruction_subset_exec dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .instr_i(instr_i),
    .file_rdata_i(file_rdata_i),
    .upper_jump_latch_i(upper_jump_latch_i),
    .program_counter_o(program_counter_o),
    .file_raddr_o(file_raddr_o),
    .file_we_o(file_we_o),
    .file_waddr_o(file_waddr_o),
    .file_wdata_o(file_wdata_o),
    .accumulator_o(accumulator_o),
    .zero_flag_o(zero_flag_o),
    .flush_o(flush_o)
  );

  always #12.5 clk_i = ~clk_i;

  // External file commits late; the core forwards the fresh value
  assign file_rdata_i = fmem[file_raddr_o];
  always @(posedge clk_i) begin
    if (file_we_o === 1'b1) begin
      fmem[file_waddr_o] <= file_wdata_o;
    end
  end

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [13:0] mk(int kd, logic d, logic [6:0] f,
                                     logic [10:0] k);
    case (kd)
      0: mk = OPC_CLEAR_ACC;
      1: mk = {OPC_DEC_SKIP, d, f};
      2: mk = {OPC_INC_SKIP, d, f};
      3: mk = {OPC_INC, d, f};
      4: mk = {OPC_OR_LIT, k[7:0]};
      5: mk = {OPC_JUMP, k};
      default: mk = {k[2:0], k};
    endcase
  endfunction

  task automatic model_reset();
    m_pc = PC_RESET;
    m_acc = ACC_RESET;
    m_z = 1'b0;
    m_we = 1'b0;
    m_fl = 1'b0;
    m_jp = 1'b0;
  endtask

  task automatic do_reset();
    reset_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    model_reset();
  endtask

  // Called at a rising edge; word runs at the next one
  task automatic step(input logic [13:0] w);
    logic [7:0] lat, fd, r;
    logic [5:0] o6;
    lat = 8'($urandom);
    instr_i <= w;
    upper_jump_latch_i <= lat;
    @(negedge clk_i);
    chk(16'(program_counter_o), 16'(m_pc));
    chk(16'(accumulator_o), 16'(m_acc));
    chk(16'(zero_flag_o), 16'(m_z));
    chk(16'(file_raddr_o), 16'(w[6:0]));
    chk({15'h0, flush_o}, {15'h0, m_fl});
    chk({15'h0, file_we_o}, {15'h0, m_we});
    if (m_we) begin
      chk(16'(file_waddr_o), 16'(m_wa));
      chk(16'(file_wdata_o), 16'(m_wd));
    end
    o6 = w[13:8];
    fd = em[w[6:0]];
    m_we = 1'b0;
    if (m_fl) begin
      m_fl = 1'b0;
      if (!m_jp) m_pc = m_pc + 13'h0001;
      m_jp = 1'b0;
    end else begin
      m_pc = m_pc + 13'h0001;
      if (w == OPC_CLEAR_ACC) begin
        m_acc = 8'h00;
        m_z = 1'b1;
      end else if (o6 == OPC_OR_LIT) begin
        m_acc = m_acc | w[7:0];
        m_z = (m_acc == 8'h00);
      end else if (w[13:11] == OPC_JUMP) begin
        m_pc = {lat[4:3], w[10:0]};
        m_fl = 1'b1;
        m_jp = 1'b1;
      end else if (o6 == OPC_INC || o6 == OPC_INC_SKIP ||
                   o6 == OPC_DEC_SKIP) begin
        r = (o6 == OPC_DEC_SKIP) ? fd - 8'h01 : fd + 8'h01;
        if (o6 == OPC_INC) m_z = (r == 8'h00);
        else m_fl = (r == 8'h00);
        if (w[DEST_BIT]) begin
          m_we = 1'b1;
          m_wa = w[6:0];
          m_wd = r;
          em[w[6:0]] = r;
        end else begin
          m_acc = r;
        end
      end
    end
    @(posedge clk_i);
  endtask

  initial begin
    #(25 * 4000);
    miscompares++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h6cb9));
    for (int i = 0; i < 128; i++) begin
      em[i] = 8'($urandom);
    end
    em[1] = 8'h01;
    em[2] = 8'hFF;
    em[3] = 8'h00;
    em[4] = 8'h02;
    fmem = em;
    model_reset();
    do_reset();
    // Hand-written corners: zero results, wrap, forwarding, dead slots
    step(mk(0, 0, 0, 0));
    step(mk(1, 0, 1, 0));
    step(mk(5, 0, 0, 11'h123));
    step(mk(3, 1, 2, 0));
    step(mk(2, 1, 2, 0));
    step(mk(1, 1, 3, 0));
    step(mk(2, 0, 3, 0));
    step(mk(4, 0, 0, 0));
    step(mk(4, 0, 0, 11'h0FF));
    step(mk(5, 0, 0, 11'h7FF));
    step(mk(5, 0, 0, 11'h000));
    step(mk(5, 0, 0, 11'h000));
    step(mk(1, 1, 4, 0));
    step(mk(1, 1, 4, 0));
    step(mk(0, 0, 0, 0));
    step(mk(3, 0, 2, 0));
    // Narrow address range keeps back-to-back reuse frequent
    for (int i = 0; i < 600; i++) begin
      step(mk($urandom % 7, 1'($urandom), 7'($urandom % 8),
              11'($urandom)));
    end
    // Reset while a jump dead cycle is pending
    step(mk(5, 0, 0, 11'h555));
    do_reset();
    step(mk(3, 0, 2, 0));
    step(mk(0, 0, 0, 0));
    step(mk(0, 0, 0, 0));
    end_sim();
  end
endmodule
`default_nettype wire
